// ==== include/dam_pkg.sv ====
// Shared constants and types for the address and strobe map link
package dam_pkg;
  localparam int NUM_BANKS      = 8;
  localparam int BANK_BITS      = 3;
  localparam int ADDR_BITS      = 16;
  localparam int COL_BITS_X4    = 11;
  localparam int COL_BITS_X8    = 10;
  localparam int ROW_BITS_X4    = 14;
  localparam int ROW_BITS_X16   = 13;
  localparam int AP_POS         = 10;
  localparam int COL_HI_POS     = 11;
  localparam int ROW_TOP_POS    = 13;
  localparam int BYTE_BITS      = 8;
  localparam int PAGE_BYTES_X8  = 1024;
  localparam int PAGE_BYTES_X16 = 2048;
  localparam int DATA_BITS      = 16;
  localparam int MASK_BITS      = 2;
  localparam int MR_SEL_BITS    = 2;
  localparam int READ_ONLY_STROBE_EN_POS    = 11;
  localparam logic [1:0] MR_BASE = 2'h0;
  localparam logic [1:0] MR_EXT1 = 2'h1;

  typedef enum logic [1:0] {
    DAM_X4,
    DAM_X8,
    DAM_X16
  } dam_width_type;

  typedef enum logic [2:0] {
    DAM_NOP,
    DAM_ACT,
    DAM_RD,
    DAM_WR,
    DAM_PRE,
    DAM_MRS
  } dam_cmd_type;

  typedef struct packed {
    logic                 cs_n;
    dam_cmd_type          cmd;
    logic [BANK_BITS-1:0] bank;
    logic [ADDR_BITS-1:0] addr;
  } dam_cmdword_type;

  // Column bits used by each organisation
  function automatic logic [ADDR_BITS-1:0] dam_col_of(input dam_width_type w,
                                                     input logic [ADDR_BITS-1:0] a);
    logic [ADDR_BITS-1:0] c;
    c = {6'h00, a[9:0]};
    if (w == DAM_X4) begin
      c[COL_BITS_X8] = a[COL_HI_POS];
    end
    return c;
  endfunction

  // Row bits used by each organisation; spare upper pins are never looked at
  function automatic logic [ADDR_BITS-1:0] dam_row_of(input dam_width_type w,
                                                     input logic [ADDR_BITS-1:0] a);
    logic [ADDR_BITS-1:0] r;
    r = {3'h0, a[12:0]};
    if (w != DAM_X16) begin
      r[ROW_TOP_POS] = a[ROW_TOP_POS];
    end
    return r;
  endfunction
endpackage

// ==== include/dam_if.sv ====
// Command, address, strobe and data link between controller and memory
`timescale 1ns/1ps
interface dam_if;
  import dam_pkg::*;
  dam_cmdword_type       cmdw;
  logic [DATA_BITS-1:0]  wdata;
  logic [MASK_BITS-1:0]  wmask;
  logic [MASK_BITS-1:0]  wstrobe;
  logic [DATA_BITS-1:0]  rdata_rise;
  logic [DATA_BITS-1:0]  rdata_fall;
  logic [MASK_BITS-1:0]  rstrobe;
  logic                  read_only_strobe;
  logic                  read_only_strobe_oe_n;

  modport ctrl (output cmdw, output wdata, output wmask, output wstrobe,
                input rdata_rise, input rdata_fall, input rstrobe, input read_only_strobe,
                input read_only_strobe_oe_n);
  modport mem  (input cmdw, input wdata, input wmask, input wstrobe,
                output rdata_rise, output rdata_fall, output rstrobe, output read_only_strobe,
                output read_only_strobe_oe_n);
endinterface

// ==== rtl/dam_lane.sv ====
// One byte lane: masked write merge and rising-edge capture of both read halves
`timescale 1ns/1ps
module dam_lane
  import dam_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         wr_en,
  input  wire logic         mask,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] mem_q,
  output logic      [W-1:0] mem_d,
  output logic              mem_we,
  input  wire logic         rd_en,
  output logic      [W-1:0] q_rise_ff,
  output logic      [W-1:0] q_fall_ff,
  output logic              strobe_ff
);
  assign mem_we = wr_en & ~mask;
  assign mem_d  = wdata;

  // Same word is presented on both halves; a real part streams a burst here
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_rise_ff <= '0;
      q_fall_ff <= '0;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= rd_en;
      if (rd_en) begin
        q_rise_ff <= mem_q;
        q_fall_ff <= mem_q;
      end
    end
  end
endmodule

// ==== rtl/dam_mem_end.sv ====
// Memory end: command sampling, address split, strobes and masks
//
// How it works
// RULE_01: Three bank bits pick one of eight banks
// RULE_02: Column uses A0-A9, plus A11 in x4
// RULE_03: A10 is auto-precharge flag, never column
// RULE_04: Page is 1 kB for x4/x8, 2 kB x16
// RULE_05: x8 read strobe only after extended mode set
// RULE_06: Read strobe enabled disables x8 write mask
// RULE_07: Enabled read strobe accompanies read data
// RULE_08: x16 upper/lower strobes time their own lanes
// RULE_09: x16 masks gate upper and lower bytes separately
// RULE_10: Commands sampled on rising true clock
// RULE_11: Read data delivered on both clock edges; here both halves are captured on the rising edge
// RULE_12: Reserved upper address pins are ignored
// RULE_13: Row bit 13 only in x4 and x8
// RULE_14: Precharge A10 low one bank, high all
// RULE_15: Low bank bits choose base or extended register
// RULE_16: Chip select high masks the command
`timescale 1ns/1ps
module dam_mem_end
  import dam_pkg::*;
#(
  parameter dam_width_type WIDTH = DAM_X8,
  parameter int            DEPTH = 64
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  dam_if.mem                        link,
  output logic [NUM_BANKS-1:0]      bank_open_ff,
  output logic [ADDR_BITS-1:0]      last_row_ff,
  output logic [ADDR_BITS-1:0]      last_col_ff,
  output logic                      last_ap_ff,
  output logic                      read_only_strobe_en_ff,
  output logic [ADDR_BITS-1:0]      mode_base_ff,
  output logic [ADDR_BITS-1:0]      mode_ext1_ff,
  output logic [15:0]               page_bytes
);
  localparam int IDXW = $clog2(DEPTH);
  localparam int LANES = (WIDTH == DAM_X16) ? 2 : 1;

  // Chip select is part of the command: a deselected word decodes as nothing
  function automatic logic issued(input dam_cmdword_type w, input dam_cmd_type k);
    return !w.cs_n && w.cmd == k;
  endfunction

  dam_cmdword_type       c;
  logic                  live;
  logic [ADDR_BITS-1:0]  col;
  logic [ADDR_BITS-1:0]  row;
  logic [IDXW-1:0]       idx;
  logic [DATA_BITS-1:0]  mem [DEPTH];
  logic [DATA_BITS-1:0]  mem_q;
  logic [DATA_BITS-1:0]  lane_d;
  logic [MASK_BITS-1:0]  lane_we;
  logic [MASK_BITS-1:0]  eff_mask;
  logic [MASK_BITS-1:0]  lane_strobe;
  logic                  is_wr;
  logic                  is_rd;
  logic                  read_only_strobe_live;

  assign c    = link.cmdw;
  assign live = ~c.cs_n;                                         // [RULE_16] [RULE_10]
  assign col  = dam_col_of(WIDTH, c.addr);                       // [RULE_02] [RULE_03]
  assign row  = dam_row_of(WIDTH, c.addr);                       // [RULE_13] [RULE_12]
  assign idx  = IDXW'(col ^ ADDR_BITS'(c.bank));                 // [RULE_01]
  assign is_wr = issued(c, DAM_WR);
  assign is_rd = issued(c, DAM_RD);
  assign read_only_strobe_live = (WIDTH == DAM_X8) && read_only_strobe_en_ff;
  assign mem_q = mem[idx];

  // Page bytes = 2^colbits x width / 8
  assign page_bytes = (WIDTH == DAM_X16) ? 16'(PAGE_BYTES_X16)
                                         : 16'(PAGE_BYTES_X8);  // [RULE_04]

  // Mask pin is dead while the x8 read strobe owns it
  always_comb begin
    eff_mask = link.wmask;
    if (read_only_strobe_live) begin
      eff_mask = '0;                                             // [RULE_06]
    end
    if (WIDTH != DAM_X16) begin
      eff_mask[1] = eff_mask[0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < MASK_BITS; g++) begin : g_lane
      dam_lane #(.W(BYTE_BITS)) u_lane (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .wr_en     (is_wr && (g < LANES || WIDTH != DAM_X16)),
        .mask      (eff_mask[g]),                                // [RULE_09]
        .wdata     (link.wdata[g*BYTE_BITS +: BYTE_BITS]),
        .mem_q     (mem_q[g*BYTE_BITS +: BYTE_BITS]),
        .mem_d     (lane_d[g*BYTE_BITS +: BYTE_BITS]),
        .mem_we    (lane_we[g]),
        .rd_en     (is_rd),
        .q_rise_ff (link.rdata_rise[g*BYTE_BITS +: BYTE_BITS]),  // [RULE_11]
        .q_fall_ff (link.rdata_fall[g*BYTE_BITS +: BYTE_BITS]),
        .strobe_ff (lane_strobe[g])                              // [RULE_08]
      );
    end
  endgenerate

  assign link.rstrobe   = lane_strobe;
  assign link.read_only_strobe      = read_only_strobe_live && lane_strobe[0];                         // [RULE_07]
  assign link.read_only_strobe_oe_n = ~read_only_strobe_live;                                          // [RULE_05]

  // Cleared at reset so an unwritten word reads as zero rather than unknown
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int j = 0; j < DEPTH; j++) begin
        mem[j] <= '0;
      end
    end else begin
      for (int i = 0; i < MASK_BITS; i++) begin
        if (lane_we[i]) begin
          mem[idx][i*BYTE_BITS +: BYTE_BITS] <= lane_d[i*BYTE_BITS +: BYTE_BITS];
        end
      end
    end
  end

  // Bank state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bank_open_ff <= '0;
    end else if (issued(c, DAM_ACT)) begin
      bank_open_ff[c.bank] <= 1'b1;                              // [RULE_01]
    end else if (issued(c, DAM_PRE)) begin
      if (c.addr[AP_POS]) begin
        bank_open_ff <= '0;                                      // [RULE_14]
      end else begin
        bank_open_ff[c.bank] <= 1'b0;                            // [RULE_14]
      end
    end else if ((is_rd || is_wr) && c.addr[AP_POS]) begin
      bank_open_ff[c.bank] <= 1'b0;                              // [RULE_03]
    end
  end

  // One row latch only; a per-bank copy is not needed to show the split
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_row_ff <= '0;
    end else if (issued(c, DAM_ACT)) begin
      last_row_ff <= row;                                        // [RULE_13]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_col_ff <= '0;
      last_ap_ff  <= 1'b0;
    end else if (is_rd || is_wr) begin
      last_col_ff <= col;
      last_ap_ff  <= c.addr[AP_POS];
    end
  end

  // Mode registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_base_ff <= '0;
    end else if (issued(c, DAM_MRS) && c.bank[MR_SEL_BITS-1:0] == MR_BASE) begin
      mode_base_ff <= c.addr;                                    // [RULE_15]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ext1_ff <= '0;
    end else if (issued(c, DAM_MRS) && c.bank[MR_SEL_BITS-1:0] == MR_EXT1) begin
      mode_ext1_ff <= c.addr;                                    // [RULE_15]
    end
  end

  // Strobe enable holds until the next extended mode write changes it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      read_only_strobe_en_ff <= 1'b0;
    end else if (issued(c, DAM_MRS) && c.bank[MR_SEL_BITS-1:0] == MR_EXT1) begin
      read_only_strobe_en_ff <= c.addr[READ_ONLY_STROBE_EN_POS];                         // [RULE_05]
    end
  end
endmodule

// ==== rtl/dam_ctrl_end.sv ====
// Controller end: registers user requests onto the link
`timescale 1ns/1ps
module dam_ctrl_end
  import dam_pkg::*;
#(
  parameter dam_width_type WIDTH = DAM_X8
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  dam_if.ctrl                       link,
  input  wire logic                 req_valid,
  input  wire dam_cmd_type          req_cmd,
  input  wire logic [BANK_BITS-1:0] req_bank,
  input  wire logic [ADDR_BITS-1:0] req_addr,
  input  wire logic [DATA_BITS-1:0] req_wdata,
  input  wire logic [MASK_BITS-1:0] req_wmask,
  output logic [DATA_BITS-1:0]      rsp_rise_ff,
  output logic [DATA_BITS-1:0]      rsp_fall_ff,
  output logic                      rsp_valid_ff
);
  dam_cmdword_type      cmd_ff;
  logic [DATA_BITS-1:0] wdata_ff;
  logic [MASK_BITS-1:0] wmask_ff;
  logic [MASK_BITS-1:0] wstb_ff;
  logic                 read_only_strobe_on;

  assign link.cmdw    = cmd_ff;
  assign link.wdata   = wdata_ff;
  assign link.wmask   = wmask_ff;
  assign link.wstrobe = wstb_ff;
  assign read_only_strobe_on      = ~link.read_only_strobe_oe_n;

  // Idle drives chip select high so the memory sees no command
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff   <= '{cs_n: 1'b1, cmd: DAM_NOP, bank: '0, addr: '0};
      wdata_ff <= '0;
      wmask_ff <= '0;
      wstb_ff  <= '0;
    end else begin
      cmd_ff.cs_n <= ~req_valid;                                 // [RULE_16]
      cmd_ff.cmd  <= req_valid ? req_cmd : DAM_NOP;
      cmd_ff.bank <= req_bank;                                   // [RULE_01] [RULE_15]
      cmd_ff.addr <= req_addr;                                   // [RULE_02] [RULE_14]
      wdata_ff    <= req_wdata;
      // Mask goes out as asked; the memory end decides if the pin still masks
      wmask_ff    <= req_wmask;                                  // [RULE_09]
      wstb_ff     <= (req_valid && req_cmd == DAM_WR) ? '1 : '0;     // [RULE_08]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_rise_ff  <= '0;
      rsp_fall_ff  <= '0;
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (WIDTH == DAM_X8 && read_only_strobe_on) ? link.read_only_strobe : link.rstrobe[0];  // [RULE_05]
      rsp_rise_ff  <= link.rdata_rise;
      rsp_fall_ff  <= link.rdata_fall;
    end
  end
endmodule

// ==== verif/dam_link_asserts.sv ====
// Assertions on the link between controller end and memory end
`timescale 1ns/1ps
module dam_link_asserts
  import dam_pkg::*;
#(
  parameter dam_width_type WIDTH = DAM_X8
) (
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire dam_cmdword_type      cmdw,
  input wire logic [MASK_BITS-1:0] wstrobe,
  input wire logic [DATA_BITS-1:0] rdata_rise,
  input wire logic [DATA_BITS-1:0] rdata_fall,
  input wire logic [MASK_BITS-1:0] rstrobe,
  input wire logic                 read_only_strobe_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic en_ff;
  sequence rd_taken;
    !cmdw.cs_n && cmdw.cmd == DAM_RD;
  endsequence
  // Tracks the read strobe enable as the memory end should see it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_ff <= 1'b0;
    end else if (!cmdw.cs_n && cmdw.cmd == DAM_MRS && cmdw.bank[1:0] == MR_EXT1) begin
      en_ff <= cmdw.addr[READ_ONLY_STROBE_EN_POS];
    end
  end
  rd_strobe_a: assert property (rd_taken |=> rstrobe != 2'h0)
    else $error("no read strobe after read");
  strobe_cause_a: assert property (rstrobe != 2'h0 |-> $past(!cmdw.cs_n && cmdw.cmd == DAM_RD))
    else $error("read strobe without read");
  edge_pair_a: assert property (rstrobe != 2'h0 |-> rdata_rise == rdata_fall)
    else $error("edge data differ");
  rdata_hold_a: assert property (rstrobe == 2'h0 |-> $stable(rdata_rise) && $stable(rdata_fall))
    else $error("read data moved");
  lane_pair_a: assert property (WIDTH == DAM_X16 && rstrobe != 2'h0 |-> rstrobe == 2'h3)
    else $error("lane strobes unpaired");
  read_only_strobe_gate_a: assert property (!read_only_strobe_oe_n |-> WIDTH == DAM_X8 && en_ff)
    else $error("read strobe driven while off");
  read_only_strobe_read_a: assert property (rstrobe != 2'h0 && en_ff && WIDTH == DAM_X8 |-> !read_only_strobe_oe_n)
    else $error("read strobe not driven");
  idle_rst_a: assert property ($rose(arst_n) |-> cmdw.cs_n && cmdw.cmd == DAM_NOP)
    else $error("command after reset");
  wr_strobe_a: assert property (wstrobe != 2'h0 |-> !cmdw.cs_n && cmdw.cmd == DAM_WR)
    else $error("write strobe without write");
endmodule

// ==== verif/test_ddr2_sdram_address_strobe_map.sv ====
// Bench: x4, x8 and x16 link pairs driven with one request stream
`timescale 1ns/1ps
module test_ddr2_sdram_address_strobe_map;
  import dam_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  dam_cmd_type req_cmd = DAM_NOP;
  logic [2:0] req_bank = 3'h0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
  logic [1:0] req_wmask = 2'h0;
  logic [15:0] rise[3], fall[3], row[3], col[3], mb[3], me[3], pg[3], rr[3], rf[3];
  logic [7:0] bo[3];
  logic rv[3], ap[3], en[3], got;
  int n_fail = 0, samples_checked = 0;
  logic [15:0] e1[3] = '{16'h1111, 16'h1111, 16'h2211};
  logic [15:0] e2[3] = '{16'h1111, 16'h3333, 16'h3311};
  logic [15:0] ca[3] = '{16'hffff, 16'h0800, 16'h0400};
  always #2 mclk = ~mclk;
  for (genvar g = 0; g < 3; g++) begin : gen_pair
    dam_if link();
    dam_ctrl_end #(.WIDTH(dam_width_type'(g))) i_dam_ctrl_end (.mclk(mclk), .arst_n(arst_n),
      .link(link), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_wmask(req_wmask),
      .rsp_rise_ff(rise[g]), .rsp_fall_ff(fall[g]), .rsp_valid_ff(rv[g]));
    dam_mem_end #(.WIDTH(dam_width_type'(g)), .DEPTH(64)) i_dam_mem_end (.mclk(mclk),
      .arst_n(arst_n), .link(link), .bank_open_ff(bo[g]), .last_row_ff(row[g]),
      .last_col_ff(col[g]), .last_ap_ff(ap[g]), .read_only_strobe_en_ff(en[g]), .mode_base_ff(mb[g]),
      .mode_ext1_ff(me[g]), .page_bytes(pg[g]));
    dam_link_asserts #(.WIDTH(dam_width_type'(g))) i_dam_link_asserts (.mclk(mclk),
      .arst_n(arst_n), .cmdw(link.cmdw), .wstrobe(link.wstrobe), .rdata_rise(link.rdata_rise),
      .rdata_fall(link.rdata_fall), .rstrobe(link.rstrobe), .read_only_strobe_oe_n(link.read_only_strobe_oe_n));
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Fixed wait covers the three-edge answer of a read
  task automatic op(input dam_cmd_type c, input logic [2:0] b, input logic [15:0] a,
                    input logic [15:0] d, input logic [1:0] m);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= d;
    req_wmask <= m;
    @(posedge mclk);
    req_valid <= 1'b0;
    got = 1'b0;
    repeat (5) begin
      @(posedge mclk);
      #1;
      if (rv[0] === 1'b1 && rv[1] === 1'b1 && rv[2] === 1'b1) begin
        got = 1'b1;
        rr = rise;
        rf = fall;
      end
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) chk(pg[i], i == 2 ? 2048 : 1024);
    for (int b = 0; b < 8; b++) op(DAM_ACT, b[2:0], 16'hffff, 16'h0, 2'h0);
    for (int i = 0; i < 3; i++) begin
      chk(bo[i], 8'hff);
      chk(row[i], i == 2 ? 16'h1fff : 16'h3fff);
    end
    op(DAM_PRE, 3'h3, 16'h0000, 16'h0, 2'h0);
    for (int i = 0; i < 3; i++) chk(bo[i], 8'hf7);
    op(DAM_PRE, 3'h0, 16'h0400, 16'h0, 2'h0);
    for (int i = 0; i < 3; i++) chk(bo[i], 8'h00);
    foreach (ca[k]) begin
      op(DAM_RD, 3'h0, ca[k], 16'h0, 2'h0);
      for (int i = 0; i < 3; i++) begin
        chk(col[i], {5'h00, ca[k][11] & (i == 0), ca[k][9:0]});
        chk(ap[i], ca[k][10]);
      end
    end
    op(DAM_MRS, 3'h4, 16'h0123, 16'h0, 2'h0);
    op(DAM_MRS, 3'h1, 16'h0042, 16'h0, 2'h0);
    for (int i = 0; i < 3; i++) begin
      chk(mb[i], 16'h0123);
      chk(me[i], 16'h0042);
    end
    chk(en[1], 1'b0);
    op(DAM_WR, 3'h2, 16'h0005, 16'h1111, 2'h0);
    op(DAM_WR, 3'h2, 16'h0005, 16'h2222, 2'h1);
    op(DAM_RD, 3'h2, 16'h0005, 16'h0, 2'h0);
    chk(got, 1'b1);
    for (int i = 0; i < 3; i++) begin
      chk(rr[i], e1[i]);
      chk(rf[i], e1[i]);
    end
    // Enabling the read strobe on x8 must defeat the write mask
    op(DAM_MRS, 3'h1, 16'h0800, 16'h0, 2'h0);
    chk(en[1], 1'b1);
    op(DAM_WR, 3'h2, 16'h0005, 16'h3333, 2'h1);
    op(DAM_RD, 3'h2, 16'h0005, 16'h0, 2'h0);
    chk(got, 1'b1);
    for (int i = 0; i < 3; i++) chk(rr[i], e2[i]);
    stop_test();
  end
endmodule
